// File: sw_pkg.sv
// Constants, register map and types for the single-wire bus master
package sw_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CW = 16;

	// Least time: round up to whole cycles, never below one
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	// Longest time: round down, never below one
	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_max

	// Line timing in nanoseconds
	localparam int RESET_LOW_NS = 480000;
	localparam int RESET_HOLD_NS = 480000;
	localparam int PRES_SAMPLE_NS = 70000;
	localparam int SLOT_NS = 65000;
	localparam int RECOV_NS = 2000;
	localparam int W1_LOW_NS = 6000;
	localparam int READ_LOW_NS = 2000;
	localparam int READ_SAMPLE_NS = 13000;
	localparam int DATA_VALID_NS = 15000;

	localparam logic [CW-1:0] PRES_CYC = CW'(cyc_min(PRES_SAMPLE_NS));
	localparam logic [CW-1:0] SLOT_CYC = CW'(cyc_min(SLOT_NS));
	localparam logic [CW-1:0] RECOV_CYC = CW'(cyc_min(RECOV_NS));
	localparam logic [CW-1:0] W1_LOW_CYC = CW'(cyc_max(W1_LOW_NS));
	localparam logic [CW-1:0] READ_LOW_CYC = CW'(cyc_min(READ_LOW_NS));
	localparam logic [CW-1:0] SAMPLE_CYC = CW'(cyc_max(READ_SAMPLE_NS));
	localparam logic [CW-1:0] VALID_CYC = CW'(cyc_max(DATA_VALID_NS));

	// Controller register map (byte addresses)
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0C;
	localparam logic [7:0] REG_CONFIG = 8'h10;

	// Operation codes in the command register
	localparam logic [2:0] OP_RESET = 3'h1;
	localparam logic [2:0] OP_WR_BYTE = 3'h2;
	localparam logic [2:0] OP_RD_BYTE = 3'h3;
	localparam logic [2:0] OP_WR_BIT = 3'h4;
	localparam logic [2:0] OP_RD_BIT = 3'h5;

	// Status and config field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_PRESENCE = 1;
	localparam int STAT_INITED = 2;
	localparam int STAT_ERR = 3;
	localparam int STAT_SPU = 4;
	localparam int STAT_PEND = 5;
	localparam int CFG_SPU = 0;

	// Sensor command codes the master tracks
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] CMD_WRITE_MEM = 8'h4E;
	localparam logic [3:0] FUNC_IDX_MATCH = 4'h9;
	localparam logic [3:0] FUNC_IDX_SKIP = 4'h1;
	localparam logic [1:0] WR_MEM_BYTES = 2'h3;
	localparam logic [3:0] IDX_MAX = 4'hF;

	// Sensor working-memory indices of the three writable bytes
	localparam logic [3:0] IDX_UPPER_ALARM = 4'h2;
	localparam logic [3:0] IDX_LOWER_ALARM = 4'h3;
	localparam logic [3:0] IDX_RESOLUTION = 4'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RST_LOW = 3'h1,
		ST_RST_WAIT = 3'h3,
		ST_SLOT = 3'h2,
		ST_RECOV = 3'h6
	} sw_state_t;
endpackage : sw_pkg

// File: sw_line_sync.sv
// Three-stage synchroniser with agreement filter for the bus line
module sw_line_sync (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic line_i,
	output logic line_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sw_sync_t;

	sw_sync_t s;
	sw_sync_t next_s;

	always_comb begin
		next_s = s;
		next_s.s1 = line_i;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// A change counts once the second and third stage agree
		if (s.s2 == s.s3) begin
			next_s.lvl = s.s3;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign line_o = s.lvl;
endmodule : sw_line_sync

// File: sw_master.sv
// Single-wire bus master: reset/presence, write and read slots, register port
//
// Added by the designer: the plain strobed port.
module sw_master import sw_pkg::*; #(
	parameter int RST_LOW_CYC = cyc_min(RESET_LOW_NS),
	parameter int RST_HOLD_CYC = cyc_min(RESET_HOLD_NS)
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe_o,
	output logic strong_pullup_o
);
	if (RST_LOW_CYC < cyc_min(RESET_LOW_NS) || RST_LOW_CYC >= 65536 ||
		RST_HOLD_CYC <= int'(PRES_CYC) + 1 || RST_HOLD_CYC >= 65536) begin : g_bad_param
		$error("sw_master: reset counts out of range");
	end

	typedef struct packed {
		sw_state_t st;
		logic [CW-1:0] cnt;
		logic [CW-1:0] oe_run;
		logic [2:0] nbits;
		logic is_rd;
		logic is_byte;
		logic [7:0] txb;
		logic [7:0] shreg;
		logic [7:0] rxsh;
		logic [7:0] txdata;
		logic [7:0] rxdata;
		logic presence;
		logic inited;
		logic err;
		logic spu_req;
		logic spu;
		logic drive;
		logic lvl;
		logic match;
		logic [3:0] byte_idx;
		logic [1:0] wr_pend;
		logic [31:0] rdata;
	} sw_regs_t;

	sw_regs_t s;
	sw_regs_t next_s;
	logic line_s;
	logic cmd_wr;
	logic [2:0] op;
	logic [CW-1:0] low_len;
	logic set_err;

	sw_line_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.line_i(line_i),
		.line_o(line_s)
	);

	assign cmd_wr = wr_i && (addr_i == REG_CMD);
	assign op = wdata_i[2:0];
	// slot low time, short read opening
	assign low_len = s.is_rd ? READ_LOW_CYC : (s.shreg[0] ? W1_LOW_CYC : SLOT_CYC);

	always_comb begin
		next_s = s;
		set_err = 1'b0;
		next_s.rdata = '0;
		next_s.oe_run = s.drive ? ((s.oe_run == '1) ? s.oe_run : s.oe_run + CW'(1)) : '0;

		// Register writes
		if (wr_i) begin
			if (addr_i == REG_TXDATA) begin
				next_s.txdata = wdata_i[7:0];
			end else if (addr_i == REG_CONFIG) begin
				next_s.spu_req = wdata_i[CFG_SPU];
			end else if (addr_i == REG_STATUS && wdata_i[STAT_ERR]) begin
				next_s.err = 1'b0;
			end
		end

		// Register reads, answered in the next cycle
		if (rd_i) begin
			if (addr_i == REG_TXDATA) begin
				next_s.rdata = {24'h000000, s.txdata};
			end else if (addr_i == REG_STATUS) begin
				next_s.rdata[STAT_BUSY] = (s.st != ST_IDLE);
				next_s.rdata[STAT_PRESENCE] = s.presence;
				next_s.rdata[STAT_INITED] = s.inited;
				next_s.rdata[STAT_ERR] = s.err;
				next_s.rdata[STAT_SPU] = s.spu;
				next_s.rdata[STAT_PEND] = (s.wr_pend != 2'h0);
			end else if (addr_i == REG_RXDATA) begin
				next_s.rdata = {24'h000000, s.rxdata};
			end else if (addr_i == REG_CONFIG) begin
				next_s.rdata[CFG_SPU] = s.spu_req;
			end
		end

		case (s.st)
			ST_RST_LOW: begin
				next_s.cnt = s.cnt + CW'(1);
				if (s.cnt == CW'(RST_LOW_CYC - 1)) begin
					next_s.drive = 1'b0;
					next_s.cnt = '0;
					next_s.st = ST_RST_WAIT;
				end
			end
			ST_RST_WAIT: begin
				next_s.cnt = s.cnt + CW'(1);
				if (s.cnt == PRES_CYC) begin
					next_s.presence = !line_s;
				end
				if (s.cnt == CW'(RST_HOLD_CYC - 1)) begin
					next_s.st = ST_IDLE;
					next_s.inited = s.presence;
				end
			end
			ST_SLOT: begin
				next_s.cnt = s.cnt + CW'(1);
				if (s.cnt == low_len - CW'(1)) begin
					next_s.drive = 1'b0;
				end
				if (s.is_rd && s.cnt == SAMPLE_CYC) begin
					next_s.rxsh = {line_s, s.rxsh[7:1]};
				end
				if (s.cnt == SLOT_CYC - CW'(1)) begin
					next_s.st = ST_RECOV;
					next_s.cnt = '0;
					next_s.drive = 1'b0;
					next_s.shreg = {1'b0, s.shreg[7:1]};
				end
			end
			ST_RECOV: begin
				next_s.cnt = s.cnt + CW'(1);
				if (s.cnt == RECOV_CYC - CW'(1)) begin
					next_s.cnt = '0;
					if (s.nbits != 3'h0) begin
						next_s.nbits = s.nbits - 3'h1;
						next_s.st = ST_SLOT;
						next_s.drive = 1'b1;
					end else begin
						next_s.st = ST_IDLE;
						// single status bit lands in bit 0
						next_s.rxdata = s.is_byte ? s.rxsh : {7'h00, s.rxsh[7]};
						if (s.is_byte && !s.is_rd) begin
							if (s.wr_pend != 2'h0) begin
								next_s.wr_pend = s.wr_pend - 2'h1;
							end else if (s.byte_idx == 4'h0) begin
								next_s.match = (s.txb == ROM_MATCH);
							end else if (s.byte_idx == (s.match ? FUNC_IDX_MATCH : FUNC_IDX_SKIP)
								&& s.txb == CMD_WRITE_MEM) begin
								next_s.wr_pend = WR_MEM_BYTES;
							end
							if (s.byte_idx != IDX_MAX) begin
								next_s.byte_idx = s.byte_idx + 4'h1;
							end
						end
					end
				end
			end
			default: begin
				next_s.cnt = '0;
			end
		endcase

		// Command start; a reset may cut a transfer short unless a memory write is pending or the pull-up is requested
		if (cmd_wr) begin
			if (op == OP_RESET) begin
				// refuse reset while pull-up or pending write
				if (s.spu_req || s.spu || s.wr_pend != 2'h0) begin
					set_err = 1'b1;
				end else begin
					next_s.st = ST_RST_LOW;
					next_s.cnt = '0;
					next_s.drive = 1'b1;
					next_s.presence = 1'b0;
					next_s.inited = 1'b0;
					next_s.byte_idx = 4'h0;
					next_s.match = 1'b0;
				end
			end else if (op >= OP_WR_BYTE && op <= OP_RD_BIT) begin
				// slots only after init, never under pull-up
				if (!s.inited || s.spu_req || s.spu || s.st != ST_IDLE) begin
					set_err = 1'b1;
				end else begin
					next_s.st = ST_SLOT;
					next_s.cnt = '0;
					next_s.drive = 1'b1;
					next_s.is_rd = (op == OP_RD_BYTE) || (op == OP_RD_BIT);
					next_s.is_byte = (op == OP_WR_BYTE) || (op == OP_RD_BYTE);
					next_s.nbits = next_s.is_byte ? 3'h7 : 3'h0;
					next_s.shreg = s.txdata;
					next_s.txb = s.txdata;
					next_s.rxsh = 8'h00;
				end
			end
		end

		// strong pull-up only with the line quiet
		next_s.spu = next_s.spu_req && (next_s.st == ST_IDLE) && !next_s.drive;
		next_s.lvl = !next_s.drive;
		if (set_err) begin
			next_s.err = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.lvl <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_o = s.rdata;
	assign line_o = s.lvl;
	assign line_oe_o = s.drive;
	assign strong_pullup_o = s.spu;

	sequence seq_reset_issue;
		wr_i && addr_i == REG_CMD && wdata_i[2:0] == OP_RESET && !s.spu_req && !s.spu
			&& s.wr_pend == 2'h0;
	endsequence

	sequence seq_reset_drive;
		line_oe_o && !line_o [*8];
	endsequence

	AST_RESET_STARTS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		seq_reset_issue |=> seq_reset_drive)
		else $error("reset request did not drive the line low");

	AST_RESET_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(line_oe_o) && $past(s.st) == ST_RST_LOW
		|-> $past(s.oe_run) >= CW'(cyc_min(RESET_LOW_NS) - 1))
		else $error("reset pulse shorter than required");

	AST_SPU_QUIET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		strong_pullup_o |-> !line_oe_o && s.st == ST_IDLE)
		else $error("line driven during strong pull-up");

	AST_W1_RELEASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(line_oe_o) && $past(s.st) == ST_SLOT && !s.is_rd && $past(s.shreg[0])
		|-> $past(s.oe_run) == W1_LOW_CYC - CW'(1))
		else $error("write one low time wrong");

	AST_READ_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(line_oe_o) && $past(s.st) == ST_SLOT && s.is_rd
		|-> $past(s.oe_run) == READ_LOW_CYC - CW'(1))
		else $error("read slot opening low time wrong");

	AST_SLOT_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_RECOV && $past(s.st) == ST_SLOT |-> $past(s.cnt) == SLOT_CYC - CW'(1)
			&& !line_oe_o)
		else $error("slot ended at wrong time");

	AST_SAMPLE_IN_VALID: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s.st == ST_SLOT && s.is_rd && s.cnt == SAMPLE_CYC |-> !line_oe_o && s.cnt < VALID_CYC)
		else $error("read sample outside valid window");

	AST_NO_SLOT_UNINIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_wr && op >= OP_WR_BYTE && op <= OP_RD_BIT && !s.inited |=> s.err && s.st != ST_SLOT)
		else $error("slot started without initialization");

	AST_PEND_BLOCKS_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_wr && op == OP_RESET && s.wr_pend != 2'h0 |=> s.err && s.st != ST_RST_LOW)
		else $error("reset accepted during memory write");
endmodule : sw_master

// File: sw_sensor.sv
// Behavioural single-wire sensor: presence, slots and scratchpad commands
module sw_sensor #(
	parameter int RST_MIN = 11500,
	parameter int PRES_WAIT = 750,
	parameter int PRES_LEN = 1500,
	parameter int SAMPLE = 750,
	parameter int HOLD = 375,
	parameter bit PARASITE = 1'b1,
	parameter logic [71:0] MEM_INIT = 72'h5A_10_00_FF_7F_46_4B_3C_A5,
	parameter logic [23:0] NV_INIT = 24'h7F_46_4B
) (
	input wire logic ref_clk_i,
	input wire logic line_i,
	output logic pull_o = 1'b0
);
	logic [71:0] mem = {MEM_INIT[71:40], NV_INIT, MEM_INIT[15:0]};
	logic [23:0] nv = NV_INIT;
	logic [71:0] tx = 72'h0;
	logic [7:0] sh = 8'h00;
	logic prev = 1'b1, rst_seen = 1'b0, drv = 1'b0, tx_slot = 1'b0;
	int cnt = 0, sc = 0, pres = -1, nb = 0, txn = 0, phase = 0, wn = 0;

	always @(posedge ref_clk_i) begin
		// low-time counter restarts on any line edge, slot counter sc only on a falling edge
		cnt = (line_i != prev) ? 0 : cnt + 1;
		sc = sc + 1;
		// long low resets and abandons transfers
		if (!line_i && cnt == RST_MIN) begin
			rst_seen = 1'b1;
			phase = 0;
			nb = 0;
			txn = 0;
			drv = 1'b0;
		end
		if (rst_seen && line_i && !prev) begin
			rst_seen = 1'b0;
			pres = 0;
		end
		if (pres >= 0) begin
			pres = pres + 1;
			drv = pres > PRES_WAIT && pres <= PRES_WAIT + PRES_LEN;
			if (pres > PRES_WAIT + PRES_LEN) pres = -1;
		end else if (!rst_seen) begin
			// answer only in master slots, hold then release
			if (prev && !line_i) begin
				sc = 0;
				tx_slot = txn > 0;
				drv = tx_slot && !tx[0];
				if (tx_slot) begin
					tx = tx >> 1;
					txn = txn - 1;
				end
			end
			if (sc == HOLD) drv = 1'b0;
			// one bit sampled inside the window
			if (sc == SAMPLE && !tx_slot) begin
				sh = {line_i, sh[7:1]};
				nb = nb + 1;
			end
			if (nb == 8) begin
				nb = 0;
				// three data bytes into bytes 2 to 4
				if (phase == 3 && wn < 3) begin
					mem[8*(2+wn) +: 8] = sh;
					wn = wn + 1;
				end
				// function byte only after the addressing byte
				if (phase == 1) begin
					phase = 2;
					case (sh)
						8'hBE: begin
							tx = mem;
							txn = 72;
						end
						8'hB4: begin
							tx = {71'h0, !PARASITE};
							txn = 1;
						end
						// conversion modelled as finished at once
						8'h44: begin
							tx = 72'h1;
							txn = PARASITE ? 0 : 1;
						end
						8'h4E: begin
							phase = 3;
							wn = 0;
						end
						8'h48: nv = mem[39:16];
						8'hB8: begin
							mem[39:16] = nv;
							tx = 72'h1;
							txn = 1;
						end
						default: ;
					endcase
				end
				if (phase == 0) phase = 1;
			end
		end
		prev = line_i;
		pull_o <= drv;
	end
endmodule : sw_sensor

// File: sw_master_tb.sv
// Testbench for the single-wire bus master against a sensor model
module sw_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sw_pkg::*;
	localparam logic [71:0] MEM0 = 72'h5A_10_00_FF_7F_46_4B_3C_A5;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic line_o, line_oe_o, strong_pullup_o, pull;
	logic [31:0] d, r;
	int seed = 32'h22CDBC7B;
	int n_errors = 0;
	int n_tests = 0;
	wire bus_line;
	assign bus_line = !((line_oe_o && !line_o) || pull);

	sw_master #(.RST_HOLD_CYC(2400)) i_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_i(bus_line), .line_o(line_o),
		.line_oe_o(line_oe_o), .strong_pullup_o(strong_pullup_o));
	sw_sensor #(.MEM_INIT(MEM0)) i_sensor (.ref_clk_i(ref_clk_i), .line_i(bus_line), .pull_o(pull));

	always #20 ref_clk_i = !ref_clk_i;

	task automatic test_done();
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] stat(input bit pres, input bit err);
		stat = 32'h0;
		stat[STAT_PRESENCE] = pres;
		stat[STAT_INITED] = pres;
		stat[STAT_ERR] = err;
	endfunction : stat

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata_o;
	endtask : bus_rd

	task automatic run_op(input logic [2:0] op, input logic [7:0] txb);
		int i;
		bus_wr(REG_TXDATA, {24'h0, txb});
		bus_wr(REG_CMD, {29'h0, op});
		for (i = 0; i < 20000; i++) begin
			bus_rd(REG_STATUS, d);
			if (d[STAT_BUSY] === 1'b0) break;
		end
		if (i == 20000) begin
			n_errors++;
			test_done();
		end
	endtask : run_op

	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		bus_rd(REG_STATUS, d);
		check(d, 32'h0);
		// Read data stand for one cycle only
		@(negedge ref_clk_i);
		check(rdata_o, 32'h0);
		bus_rd(8'h14, d);
		check(d, 32'h0);
		r = $random(seed);
		bus_wr(REG_TXDATA, r);
		bus_rd(REG_TXDATA, d);
		check(d, {24'h0, r[7:0]});
		// Slot before any reset is refused, then the error is cleared
		bus_wr(REG_CMD, {29'h0, OP_RD_BIT});
		bus_rd(REG_STATUS, d);
		check(d, stat(1'b0, 1'b1));
		bus_wr(REG_STATUS, 32'h8);
		bus_rd(REG_STATUS, d);
		check(d, stat(1'b0, 1'b0));
		bus_wr(REG_CONFIG, 32'h1);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, strong_pullup_o}, 32'h1);
		bus_wr(REG_CONFIG, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, strong_pullup_o}, 32'h0);
		run_op(OP_RESET, 8'h00);
		check(d, stat(1'b1, 1'b0));
		// Slot and reset both refused while the pull-up is requested
		bus_wr(REG_CONFIG, 32'h1);
		bus_wr(REG_CMD, {29'h0, OP_WR_BYTE});
		bus_wr(REG_CMD, {29'h0, OP_RESET});
		bus_rd(REG_STATUS, d);
		check(d, stat(1'b1, 1'b1) | (32'h1 << STAT_SPU));
		bus_wr(REG_CONFIG, 32'h0);
		bus_wr(REG_STATUS, 32'h8);
		run_op(OP_WR_BYTE, 8'hCC);
		run_op(OP_WR_BYTE, 8'hBE);
		run_op(OP_RD_BYTE, 8'h00);
		bus_rd(REG_RXDATA, d);
		check(d, {24'h0, MEM0[7:0]});
		run_op(OP_RD_BIT, 8'h00);
		bus_rd(REG_RXDATA, d);
		check({31'h0, d[0]}, {31'h0, MEM0[8]});
		// Cut a read short with a reset part way through
		bus_wr(REG_CMD, {29'h0, OP_RD_BYTE});
		bus_wr(REG_CMD, {29'h0, OP_WR_BIT});
		bus_rd(REG_STATUS, d);
		check(d, stat(1'b1, 1'b1) | (32'h1 << STAT_BUSY));
		bus_wr(REG_STATUS, 32'h8);
		repeat (200 + $unsigned($random(seed)) % 400) @(posedge ref_clk_i);
		run_op(OP_RESET, 8'h00);
		check(d, stat(1'b1, 1'b0));
		run_op(OP_WR_BYTE, 8'hCC);
		run_op(OP_WR_BYTE, 8'hB4);
		run_op(OP_RD_BIT, 8'h00);
		bus_rd(REG_RXDATA, d);
		check({31'h0, d[0]}, 32'h0);
		check({31'h0, bus_line}, 32'h1);
		test_done();
	end
endmodule : sw_master_tb
